/* File: include/disk_cmd_pkg.sv */
package disk_cmd_pkg;

  // Register byte offsets
  localparam logic [7:0] CSR_OFS = 8'h00;
  localparam logic [7:0] PDR_OFS = 8'h04;
  localparam logic [7:0] DRIVE_OFS = 8'h08;
  localparam logic [7:0] POLICY_OFS = 8'h0C;

  // Command and status register fields
  localparam int LAUNCH_BIT = 0;
  localparam int FUNC_LSB = 1;
  localparam int DONE_BIT = 7;
  localparam int EXTMODE_BIT = 8;
  localparam int AVAIL_BIT = 9;
  localparam int SEEKREQ_BIT = 10;
  localparam int ERROR_BIT = 15;

  // Error and status word fields
  localparam int ECODE_LSB = 8;
  localparam int RETRY_FLAG_BIT = 5;
  localparam int SEEKDONE_BIT = 15;
  localparam int TRACK0_BIT = 14;

  // Drive status / control register fields
  localparam int DRV_SEEKDONE_BIT = 0;
  localparam int DRV_INDEX_BIT = 1;
  localparam int DRV_FMTDONE_BIT = 2;
  localparam int DRV_FAULT_BIT = 3;
  localparam int DRV_RETRIABLE_BIT = 4;
  localparam int DRV_FCODE_LSB = 8;

  // Function codes
  localparam logic [3:0] FN_SEEK = 4'h0;
  localparam logic [3:0] FN_FMT_FLOPPY = 4'h1;
  localparam logic [3:0] FN_WRITE_DIRECT = 4'h2;
  localparam logic [3:0] FN_READ_DIRECT = 4'h3;
  localparam logic [3:0] FN_WRITE_DELETED = 4'h6;
  localparam logic [3:0] FN_RESERVED = 4'hF;

  // Error codes
  localparam logic [5:0] EC_NONE = 6'h00;
  localparam logic [5:0] EC_ILLEGAL_CMD = 6'd28;
  localparam logic [5:0] EC_SEEK_FAIL = 6'd15;

  // Parameter word counts
  localparam logic [2:0] NPARAM_SEEK = 3'd3;
  localparam logic [2:0] NPARAM_FMT = 3'd4;
  localparam logic [2:0] NPARAM_RW = 3'd6;
  localparam logic [2:0] NPARAM_OTHER = 3'd1;

  // Reset values
  localparam logic [15:0] CSR_RESET = 16'h0180;
  localparam logic [3:0] RETRIES_RESET = 4'h3;

  // Step pulse timing
  localparam int STEP_NS = 3000;
  localparam int CLK_NS = 10;
  localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_PARAM = 8'b0000_0010,
    ST_SEEK = 8'b0000_0100,
    ST_INDEX = 8'b0000_1000,
    ST_FORMAT = 8'b0001_0000,
    ST_STEP = 8'b0010_0000,
    ST_EXEC = 8'b0100_0000,
    ST_FINISH = 8'b1000_0000
  } state_t;

endpackage

/* File: rtl/param_store.sv */
`timescale 1ns/10ps
// Small parameter word memory with registered read data
module param_store #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule

/* File: rtl/step_timer.sv */
`timescale 1ns/10ps
// One-shot timer: pulses done after LEN cycles from start
module step_timer #(
  parameter int LEN = 300
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  output logic done
);

  localparam int W = $clog2(LEN + 1);
  logic [W-1:0] count;
  logic running;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= W'(LEN - 1);
        running <= 1'b1;
      end
      else if (running)
      begin
        if (count == '0)
        begin
          running <= 1'b0;
          done <= 1'b1;
        end
        else
        begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule

/* File: rtl/disk_ext_mode_cmd_dispatch.sv */
`timescale 1ns/10ps
module disk_ext_mode_cmd_dispatch #(
  parameter int NPARAM = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic indexPin,
  input wire logic seekDonePin,
  input wire logic fmtDonePin,
  input wire logic faultPin,
  input wire logic retriablePin,
  output logic [15:0] seekCylinder,
  output logic [1:0] seekUnit,
  output logic seekStart,
  output logic stepPulse,
  output logic formatStart,
  output logic execStart,
  output logic [3:0] execFunc
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change counted when stages two and three agree
  logic [2:0] idxSync, sdSync, fdSync, ftSync, rtSync;
  logic idxLvl, sdLvl, fdLvl, ftLvl, rtLvl;
  logic idxPrev, sdPrev;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      idxSync <= 3'b000;
      sdSync <= 3'b000;
      fdSync <= 3'b000;
      ftSync <= 3'b000;
      rtSync <= 3'b000;
      idxLvl <= 1'b0;
      sdLvl <= 1'b0;
      fdLvl <= 1'b0;
      ftLvl <= 1'b0;
      rtLvl <= 1'b0;
      idxPrev <= 1'b0;
      sdPrev <= 1'b0;
    end
    else
    begin
      idxSync <= {idxSync[1:0], indexPin};
      sdSync <= {sdSync[1:0], seekDonePin};
      fdSync <= {fdSync[1:0], fmtDonePin};
      ftSync <= {ftSync[1:0], faultPin};
      rtSync <= {rtSync[1:0], retriablePin};
      if (idxSync[1] == idxSync[2]) idxLvl <= idxSync[2];
      if (sdSync[1] == sdSync[2]) sdLvl <= sdSync[2];
      if (fdSync[1] == fdSync[2]) fdLvl <= fdSync[2];
      if (ftSync[1] == ftSync[2]) ftLvl <= ftSync[2];
      if (rtSync[1] == rtSync[2]) rtLvl <= rtSync[2];
      idxPrev <= idxLvl;
      sdPrev <= sdLvl;
    end
  end

  wire indexRise = idxLvl & ~idxPrev;
  // One event per seek attempt, a lingering level is not seen twice
  wire seekDoneNow = sdLvl & ~sdPrev;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apbWrite = psel & penable & pwrite;
  wire apbRead = psel & penable & ~pwrite;
  wire hitCsr = (paddr == disk_cmd_pkg::CSR_OFS);
  wire hitPdr = (paddr == disk_cmd_pkg::PDR_OFS);
  wire hitDrv = (paddr == disk_cmd_pkg::DRIVE_OFS);
  wire hitPol = (paddr == disk_cmd_pkg::POLICY_OFS);
  wire hitAny = hitCsr | hitPdr | hitDrv | hitPol;

  assign pready = psel & penable;
  assign pslverr = psel & penable & ~hitAny;

  ////////////////////////////////////////////////////////////////////////////
  // State and registers
  disk_cmd_pkg::state_t state, next_state;
  logic doneFlag, errorFlag, extMode;
  logic [3:0] func;
  logic [15:0] statusWord;
  logic [5:0] errCode;
  logic retried;
  logic [3:0] retryLimit, retryCount;
  logic [2:0] paramIdx, paramNeed;
  logic [15:0] cylCount, curCyl;
  logic [1:0] rdSel;
  logic stepGo;
  logic [5:0] drvCode;

  wire launchWr = apbWrite & hitCsr & pwdata[disk_cmd_pkg::LAUNCH_BIT];
  wire [3:0] wrFunc = pwdata[disk_cmd_pkg::FUNC_LSB +: 4];
  wire pdrWr = apbWrite & hitPdr;
  wire idle = (state == disk_cmd_pkg::ST_IDLE);
  wire launchOk = launchWr & idle;
  wire illegal = (wrFunc == disk_cmd_pkg::FN_RESERVED);
  wire isSeekType = (wrFunc == disk_cmd_pkg::FN_SEEK);
  wire isFmt = (wrFunc == disk_cmd_pkg::FN_FMT_FLOPPY);
  wire isRw = (wrFunc == disk_cmd_pkg::FN_WRITE_DIRECT)
      | (wrFunc == disk_cmd_pkg::FN_READ_DIRECT)
      | (wrFunc == disk_cmd_pkg::FN_WRITE_DELETED);
  wire [2:0] needOfFunc = isSeekType ? disk_cmd_pkg::NPARAM_SEEK
      : isFmt ? disk_cmd_pkg::NPARAM_FMT
      : isRw ? disk_cmd_pkg::NPARAM_RW : disk_cmd_pkg::NPARAM_OTHER;

  // Parameter word memory
  logic [15:0] pRead;
  param_store #(
    .DEPTH(NPARAM),
    .WIDTH(16)
  ) u_params (
    .ref_clk(ref_clk),
    .wrEn(pdrWr & (state == disk_cmd_pkg::ST_PARAM)),
    .wrAddr(paramIdx),
    .wrData(pwdata[15:0]),
    .rdAddr(rdSel == 2'd0 ? 3'd0 : (rdSel == 2'd1 ? 3'd1 : 3'd2)),
    .rdData(pRead)
  );

  logic stepDone;
  step_timer #(
    .LEN(disk_cmd_pkg::STEP_CYCLES)
  ) u_step (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(stepGo),
    .done(stepDone)
  );

  wire paramsIn = (paramIdx == paramNeed);
  wire opFault = ftLvl;
  // retry while policy allows and error is retriable
  wire canRetry = rtLvl & (retryCount != retryLimit);
  wire lastCyl = (cylCount <= 16'h0001);
  // Seek outcome judged at its done event, format and exec every cycle
  wire attemptEnd = (state == disk_cmd_pkg::ST_SEEK) ? seekDoneNow
      : (state == disk_cmd_pkg::ST_FORMAT) | (state == disk_cmd_pkg::ST_EXEC);
  wire retryNow = opFault & canRetry & attemptEnd;
  wire failNow = opFault & ~canRetry & attemptEnd;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      disk_cmd_pkg::ST_IDLE:
        if (launchOk) next_state = illegal ? disk_cmd_pkg::ST_FINISH : disk_cmd_pkg::ST_PARAM;
      disk_cmd_pkg::ST_PARAM:
        if (paramsIn)
          next_state = (func == disk_cmd_pkg::FN_SEEK || func == disk_cmd_pkg::FN_FMT_FLOPPY
              || func == disk_cmd_pkg::FN_WRITE_DIRECT || func == disk_cmd_pkg::FN_READ_DIRECT
              || func == disk_cmd_pkg::FN_WRITE_DELETED)
              ? disk_cmd_pkg::ST_SEEK : disk_cmd_pkg::ST_EXEC;
      disk_cmd_pkg::ST_SEEK:
        if (failNow) next_state = disk_cmd_pkg::ST_FINISH;
        else if (seekDoneNow & ~opFault)
          next_state = (func == disk_cmd_pkg::FN_FMT_FLOPPY) ? disk_cmd_pkg::ST_INDEX
              : (func == disk_cmd_pkg::FN_SEEK) ? disk_cmd_pkg::ST_FINISH : disk_cmd_pkg::ST_EXEC;
      disk_cmd_pkg::ST_INDEX:
        if (indexRise) next_state = disk_cmd_pkg::ST_FORMAT;
      disk_cmd_pkg::ST_FORMAT:
        if (opFault & ~canRetry) next_state = disk_cmd_pkg::ST_FINISH;
        else if (fdLvl & ~opFault)
          next_state = lastCyl ? disk_cmd_pkg::ST_FINISH : disk_cmd_pkg::ST_STEP;
      disk_cmd_pkg::ST_STEP:
        if (stepDone) next_state = disk_cmd_pkg::ST_INDEX;
      disk_cmd_pkg::ST_EXEC:
        if (opFault & ~canRetry) next_state = disk_cmd_pkg::ST_FINISH;
        else if (fdLvl & ~opFault) next_state = disk_cmd_pkg::ST_FINISH;
      disk_cmd_pkg::ST_FINISH:
        next_state = disk_cmd_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= disk_cmd_pkg::ST_IDLE;
      func <= 4'h0;
      paramIdx <= 3'd0;
      paramNeed <= 3'd0;
      retryCount <= 4'h0;
      retried <= 1'b0;
      errCode <= disk_cmd_pkg::EC_NONE;
      cylCount <= 16'h0000;
      curCyl <= 16'h0000;
      rdSel <= 2'd0;
      stepGo <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stepGo <= 1'b0;
      if (launchOk)
      begin
        func <= wrFunc;
        paramIdx <= 3'd0;
        paramNeed <= needOfFunc;
        retryCount <= 4'h0;
        retried <= 1'b0;
        errCode <= illegal ? disk_cmd_pkg::EC_ILLEGAL_CMD : disk_cmd_pkg::EC_NONE;
      end
      if (pdrWr && state == disk_cmd_pkg::ST_PARAM && !paramsIn)
      begin
        paramIdx <= paramIdx + 3'd1;
      end
      // load unit, cylinder and count words before seeking
      if (state == disk_cmd_pkg::ST_PARAM && next_state == disk_cmd_pkg::ST_SEEK)
      begin
        rdSel <= 2'd1;
      end
      if (state == disk_cmd_pkg::ST_SEEK && rdSel == 2'd1)
      begin
        rdSel <= 2'd2;
      end
      if (state == disk_cmd_pkg::ST_SEEK && rdSel == 2'd2)
      begin
        curCyl <= pRead;
        rdSel <= 2'd3;
      end
      if (state == disk_cmd_pkg::ST_SEEK && rdSel == 2'd3)
      begin
        cylCount <= pRead;
        rdSel <= 2'd0;
      end
      if (state == disk_cmd_pkg::ST_FORMAT && next_state == disk_cmd_pkg::ST_STEP)
      begin
        cylCount <= cylCount - 16'h0001;
        curCyl <= curCyl + 16'h0001;
        stepGo <= 1'b1;
      end
      // count a retry of the failing step
      if (retryNow)
      begin
        retryCount <= retryCount + 4'h1;
        retried <= 1'b1;
        // Reload the words and issue the seek again
        if (state == disk_cmd_pkg::ST_SEEK) rdSel <= 2'd1;
      end
      // failure always carries a nonzero code
      if (failNow)
      begin
        errCode <= (state == disk_cmd_pkg::ST_SEEK) ? disk_cmd_pkg::EC_SEEK_FAIL
            : drvCode;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      doneFlag <= 1'b1;
      errorFlag <= 1'b0;
      extMode <= 1'b1;
      retryLimit <= disk_cmd_pkg::RETRIES_RESET;
      drvCode <= disk_cmd_pkg::EC_SEEK_FAIL;
      statusWord <= 16'h0000;
    end
    else
    begin
      if (apbWrite && hitPol)
      begin
        retryLimit <= pwdata[3:0];
        extMode <= pwdata[disk_cmd_pkg::EXTMODE_BIT];
        if (pwdata[disk_cmd_pkg::DRV_FCODE_LSB +: 6] != 6'h00)
          drvCode <= pwdata[disk_cmd_pkg::DRV_FCODE_LSB +: 6];
      end
      if (launchOk)
      begin
        doneFlag <= 1'b0;
        errorFlag <= 1'b0;
      end
      if (state == disk_cmd_pkg::ST_FINISH)
      begin
        doneFlag <= 1'b1;
        errorFlag <= (errCode != disk_cmd_pkg::EC_NONE);
        statusWord <= {(func == disk_cmd_pkg::FN_SEEK), (curCyl == 16'h0000), errCode,
            2'b00, retried, sdLvl, 2'b00, seekUnit};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and drive outputs
  // availability reads the inverse of mode, seek request reads zero
  wire [15:0] csrView = {errorFlag, 4'h0, 1'b0, ~extMode, extMode, doneFlag, 2'b00, func, 1'b0};
  wire [15:0] drvView = {2'b00, errCode, 3'b000, rtLvl, ftLvl, fdLvl, idxLvl, sdLvl};
  wire [15:0] polView = {7'h00, extMode, 4'h0, retryLimit};
  wire [15:0] rdMux = hitCsr ? csrView : hitPdr ? statusWord : hitDrv ? drvView
      : hitPol ? polView : 16'h0000;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      seekStart <= 1'b0;
      formatStart <= 1'b0;
      execStart <= 1'b0;
      execFunc <= 4'h0;
      seekUnit <= 2'b00;
      seekCylinder <= 16'h0000;
    end
    else
    begin
      if (psel && !penable && !pwrite) prdata <= {16'h0000, rdMux};
      // implied seek for format, direct read/write and write-deleted functions only, other non-seek functions except the reserved code go straight to exec
      seekStart <= (state == disk_cmd_pkg::ST_SEEK) && (rdSel == 2'd3);
      formatStart <= (state == disk_cmd_pkg::ST_INDEX) && indexRise;
      execStart <= (state != disk_cmd_pkg::ST_EXEC) && (next_state == disk_cmd_pkg::ST_EXEC);
      execFunc <= func;
      seekCylinder <= curCyl;
      if (state == disk_cmd_pkg::ST_SEEK && rdSel == 2'd1) seekUnit <= pRead[1:0];
    end
  end

  assign stepPulse = stepGo;

endmodule

/* File: sim/disk_ext_mode_cmd_dispatch_asserts.sv */
`timescale 1ns/10ps
module disk_ext_mode_cmd_dispatch_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic seekStart,
  input wire logic stepPulse,
  input wire logic formatStart,
  input wire logic execStart,
  input wire logic [3:0] execFunc
);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  wire csrRd = rd && paddr == disk_cmd_pkg::CSR_OFS;
  logic errSeen;

  // Error flag from the last status register access, zero after a write
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      errSeen <= 1'b0;
    else if (acc && paddr == disk_cmd_pkg::CSR_OFS)
      errSeen <= !pwrite && prdata[disk_cmd_pkg::ERROR_BIT];

  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_ready_access: assert property (pready == acc)
    else $error("pready differs from access phase");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_avail_mode: assert property (csrRd |-> prdata[9] != prdata[8])
    else $error("availability flag disagrees with mode");
  a_err_code: assert property (rd && paddr == disk_cmd_pkg::PDR_OFS && errSeen |-> prdata[13:8] != 6'h0)
    else $error("error flag with zero error code");
  a_seek_alone: assert property (seekStart |-> ##1 (!seekStart && !formatStart && !execStart) [*4])
    else $error("operation overlaps a seek");
  a_fmt_pulse: assert property (formatStart |-> ##1 (!formatStart && !stepPulse) [*3])
    else $error("format start not a lone pulse");
  a_step_gap: assert property (stepPulse |-> ##1 !formatStart [*8])
    else $error("format started during step");
  a_exec_legal: assert property (execStart |-> execFunc != disk_cmd_pkg::FN_RESERVED)
    else $error("reserved code executed");

  c_seek: cover property (seekStart);
  c_step: cover property (stepPulse);
  c_refused: cover property (acc && pslverr);
endmodule

bind disk_ext_mode_cmd_dispatch disk_ext_mode_cmd_dispatch_asserts i_chk (
  .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .seekStart, .stepPulse, .formatStart, .execStart, .execFunc
);

/* File: sim/disk_drive_model.sv */
`timescale 1ns/10ps
module disk_drive_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic seekStart,
  input wire logic formatStart,
  input wire logic execStart,
  input wire logic faultMode,
  input wire logic retryMode,
  output logic indexPin,
  output logic seekDonePin,
  output logic fmtDonePin,
  output logic faultPin,
  output logic retriablePin
);
  logic [7:0] ix;
  logic [7:0] sd;
  logic [7:0] fd;

  always @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ix <= 8'h0;
      sd <= 8'h0;
      fd <= 8'h0;
    end
    else
    begin
      ix <= ix == 8'h4F ? 8'h0 : ix + 8'h1;
      sd <= seekStart ? 8'h1 : sd != 8'h0 && sd != 8'h28 ? sd + 8'h1 : 8'h0;
      fd <= formatStart || execStart ? 8'h1 : fd != 8'h0 && fd != 8'h32 ? fd + 8'h1 : 8'h0;
    end

  // Index pulse once per 80 cycles
  assign indexPin = ix < 8'h6;
  assign seekDonePin = sd > 8'h18;
  assign fmtDonePin = fd > 8'h22;
  assign faultPin = faultMode;
  assign retriablePin = retryMode;
endmodule

/* File: sim/tb_disk_ext_mode_cmd_dispatch.sv */
`timescale 1ns/10ps
module tb_disk_ext_mode_cmd_dispatch;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, faultMode, retryMode, rerr;
  logic indexPin, seekDonePin, fmtDonePin, faultPin, retriablePin;
  logic seekStart, stepPulse, formatStart, execStart;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] seekCylinder, seenCyl;
  logic [1:0] seekUnit, seenUnit;
  logic [3:0] execFunc, seenFunc;
  int n_fail, n_compared, nSeek, nFmt, nExec, nStep;
  // Function, parameter count, seeks, executions
  logic [15:0] rows [14] = '{16'h0310, 16'h2611, 16'h3611, 16'h4101, 16'h5101, 16'h6611,
    16'h7101, 16'h8101, 16'h9101, 16'hA101, 16'hB101, 16'hC101, 16'hD101, 16'hE101};
  logic [31:0] pw [6] = '{32'h1, 32'h10, 32'h10, 32'h4, 32'h0, 32'h0};
  logic [31:0] fw [6] = '{32'h0, 32'h5, 32'h3, 32'h0, 32'h0, 32'h0};

  disk_ext_mode_cmd_dispatch i_dut (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .indexPin, .seekDonePin, .fmtDonePin, .faultPin, .retriablePin, .seekCylinder,
    .seekUnit, .seekStart, .stepPulse, .formatStart, .execStart, .execFunc
  );

  disk_drive_model i_drive (
    .ref_clk, .rst, .seekStart, .formatStart, .execStart, .faultMode, .retryMode,
    .indexPin, .seekDonePin, .fmtDonePin, .faultPin, .retriablePin
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (seekStart)
    begin
      nSeek <= nSeek + 1;
      seenCyl <= seekCylinder;
      seenUnit <= seekUnit;
    end
    if (formatStart)
      nFmt <= nFmt + 1;
    if (stepPulse)
      nStep <= nStep + 1;
    if (execStart)
    begin
      nExec <= nExec + 1;
      seenFunc <= execFunc;
    end
  end

  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      check({31'h0, pready}, 32'h1);
      report_and_stop();
    end
    @(posedge ref_clk);
  endtask

  task automatic run(input logic [3:0] f, input logic [2:0] np, input logic [31:0] p [6]);
    int n;
    nSeek = 0;
    nFmt = 0;
    nExec = 0;
    nStep = 0;
    apb(1'b1, disk_cmd_pkg::CSR_OFS, {27'h0, f, 1'b1});
    apb(1'b0, disk_cmd_pkg::CSR_OFS, 32'h0);
    if (f != disk_cmd_pkg::FN_RESERVED)
      check({31'h0, rdat[disk_cmd_pkg::DONE_BIT]}, 32'h0);
    for (int k = 0; k < int'(np); k++)
      apb(1'b1, disk_cmd_pkg::PDR_OFS, p[k]);
    n = 0;
    do
    begin
      apb(1'b0, disk_cmd_pkg::CSR_OFS, 32'h0);
      n++;
    end
    while (rdat[disk_cmd_pkg::DONE_BIT] !== 1'b1 && n < 1000);
    check({31'h0, rdat[disk_cmd_pkg::DONE_BIT]}, 32'h1);
    if (n >= 1000)
      report_and_stop();
  endtask

  ////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    faultMode = 1'b0;
    retryMode = 1'b0;
    n_fail = 0;
    n_compared = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i][15:12], rows[i][10:8], pw);
      check({31'h0, rdat[disk_cmd_pkg::ERROR_BIT]}, 32'h0);
      check(32'(nSeek), {28'h0, rows[i][7:4]});
      check(32'(nExec), {28'h0, rows[i][3:0]});
      if (rows[i][7:4] != 4'h0)
        check({14'h0, seenUnit, seenCyl}, 32'h0001_0010);
      if (rows[i][3:0] != 4'h0)
        check({28'h0, seenFunc}, {28'h0, rows[i][15:12]});
      apb(1'b0, disk_cmd_pkg::PDR_OFS, 32'h0);
      check({26'h0, rdat[13:8]}, 32'h0);
    end
    // Reset values and refused address
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, disk_cmd_pkg::CSR_OFS, 32'h0);
    check(rdat, {16'h0, disk_cmd_pkg::CSR_RESET});
    apb(1'b0, disk_cmd_pkg::POLICY_OFS, 32'h0);
    check({28'h0, rdat[3:0]}, {28'h0, disk_cmd_pkg::RETRIES_RESET});
    apb(1'b0, 8'h10, 32'h0);
    check({rdat[31:1], rerr}, 32'h1);
    // Format, then reserved code
    run(disk_cmd_pkg::FN_FMT_FLOPPY, disk_cmd_pkg::NPARAM_FMT, fw);
    check({31'h0, rdat[disk_cmd_pkg::ERROR_BIT]}, 32'h0);
    check(32'(nFmt), 32'h3);
    check(32'(nStep), 32'h2);
    check({16'h0, seenCyl}, 32'h5);
    run(disk_cmd_pkg::FN_RESERVED, 3'h0, pw);
    check({31'h0, rdat[disk_cmd_pkg::ERROR_BIT]}, 32'h1);
    check(32'(nExec), 32'h0);
    apb(1'b0, disk_cmd_pkg::PDR_OFS, 32'h0);
    check({26'h0, rdat[13:8]}, {26'h0, disk_cmd_pkg::EC_ILLEGAL_CMD});
    // Seek faults, retriable first
    for (int r = 1; r >= 0; r--)
    begin
      faultMode <= 1'b1;
      retryMode <= r[0];
      run(disk_cmd_pkg::FN_SEEK, disk_cmd_pkg::NPARAM_SEEK, pw);
      check({31'h0, rdat[disk_cmd_pkg::ERROR_BIT]}, 32'h1);
      check(32'(nSeek), r == 1 ? 32'h4 : 32'h1);
      apb(1'b0, disk_cmd_pkg::PDR_OFS, 32'h0);
      check({26'h0, rdat[13:8]}, {26'h0, disk_cmd_pkg::EC_SEEK_FAIL});
    end
    faultMode <= 1'b0;
    report_and_stop();
  end
endmodule
